// ===== pkg/lcdbc_pkg.sv
/*
 * Constants, register map and types of the segment LCD drive and bias control block.
 * Assumes a 100 MHz single clock and a 32-bit AHB-Lite register bus.
 */
package lcdbc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] VOLT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] MEM_OFS = 8'h10;
    localparam int MEM_WORDS = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_ENABLE_POS = 0;
    localparam int CTRL_VISIBLE_POS = 2;
    localparam int CTRL_MUX_POS = 3;
    localparam int CTRL_HALF_POS = 5;

    // Voltage register fields
    localparam int VOLT_LEVEL_POS = 0;
    localparam int VOLT_PUMP_EN_POS = 4;
    localparam int VOLT_EXT_SUP_POS = 5;
    localparam int VOLT_REF_POS = 6;
    localparam int VOLT_EXT_BIAS_POS = 8;
    localparam int VOLT_LOW_EXT_POS = 9;

    // Status register fields
    localparam int STAT_SUPPLY_POS = 0;
    localparam int STAT_PUMP_RUN_POS = 2;
    localparam int STAT_BIAS_EN_POS = 3;
    localparam int STAT_OSC_STOP_POS = 4;
    localparam int STAT_PHASE_POS = 5;
    localparam int STAT_POL_POS = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Glass geometry
    localparam int SEG_PINS = 40;
    localparam int COM_LINES = 4;
    localparam int MEM_BITS = SEG_PINS * COM_LINES;

    // Encodings and reset values
    localparam logic [3:0] LEVEL_OFF = 4'h0;
    localparam logic [1:0] REF_NONE = 2'h0;
    localparam logic [1:0] REF_EXT_PIN = 2'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Common-line phase timing
    localparam int CLK_MHZ = 100;
    localparam int PHASE_TIME_US = 1000;
    localparam int PHASE_CYCLES = PHASE_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {MUX_STATIC, MUX_2, MUX_3, MUX_4} lcdbc_mux_type;
    typedef enum logic [1:0] {SUP_AVCC, SUP_PUMP, SUP_HELD, SUP_EXT_PIN} lcdbc_supply_type;

endpackage

// ===== pkg/lcdbc_seg_if.sv
/*
 * Carrier between the control core and the segment gating module.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface lcdbc_seg_if;
    logic [lcdbc_pkg::MEM_BITS-1:0] mem;
    logic [1:0] phase;
    logic enable;
    logic visible;
    logic polarity;
    logic [lcdbc_pkg::SEG_PINS-1:0] seg_on;
    logic [lcdbc_pkg::COM_LINES-1:0] com_on;
    logic drive_pol;

    modport ctl(output mem, phase, enable, visible, polarity,
                input seg_on, com_on, drive_pol);
    modport mux(input mem, phase, enable, visible, polarity,
                output seg_on, com_on, drive_pol);
endinterface

// ===== logic/lcdbc_segmux.sv
/*
 * Segment gating: picks each pin's memory bit for the active common line.
 * Assumes phase never exceeds the mux rate minus one; the core guarantees it.
 */
`timescale 1ns/100ps
module lcdbc_segmux (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    lcdbc_seg_if.mux seg
);

    typedef struct packed {
        logic [lcdbc_pkg::SEG_PINS-1:0] seg_on;
        logic [lcdbc_pkg::COM_LINES-1:0] com_on;
        logic drive_pol;
    } lcdbc_segmux_state_type;

    lcdbc_segmux_state_type r;
    lcdbc_segmux_state_type next_r;

    always_comb begin
        next_r = '0;
        // Disabled glass sees all lines at rest, no ac drive
        if (seg.enable) begin
            next_r.com_on[seg.phase] = 1'b1;
            next_r.drive_pol = seg.polarity;
            for (int s = 0; s < lcdbc_pkg::SEG_PINS; s++) begin
                // Pin s keeps its N segments in nibble bits 0..N-1
                next_r.seg_on[s] = seg.visible
                    & seg.mem[s * lcdbc_pkg::COM_LINES + int'(seg.phase)];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign seg.seg_on = r.seg_on;
    assign seg.com_on = r.com_on;
    assign seg.drive_pol = r.drive_pol;

endmodule

// ===== logic/lcdbc_top.sv
/*
 * Segment LCD drive and bias control: registers, supply and bias source selection,
 * common-line phase sequencing and segment output gating.
 * Assumes an AHB-Lite master with single word transfers and an analog macro that
 * obeys the source and enable levels driven here.
 */
// Function
// - A set display-memory bit turns its segment on; unused bits depend on mux rate.
// - Segments-visible bit is ANDed with each segment bit; zero blanks all.
// - Oscillator stopped or module disabled turns off all internal voltage generation.
// - Supply from analog rail when external select, pump level, reference all zero.
// - Supply from charge pump when not external, pump enabled, level nonzero.
// - Pump disabled with nonzero level pauses; held capacitor then supplies the glass.
// - Reference select 01 makes pump regulate to three times reference, ignoring level.
// - External supply select takes supply from capacitor pin and forces pump off.
// - External bias select takes middle rails from pins and stops internal generator.
// - Lowest-rail external select takes the lowest rail from its pin.
// - With external divider, top rail pin is switched output, or input when external.
// - In multiplexed modes half-bias select gives 1/2 bias, else 1/3 bias.
// - Static mode disables the bias divider; only top and bottom rails used.
// - Mux field: 00 static, 01 2-mux, 10 3-mux, 11 4-mux.
// - N-mux pin carries N segments over commons 0..N-1; static uses common 0.
`timescale 1ns/100ps
module lcdbc_top #(
    parameter int PHASE_CYCLES = lcdbc_pkg::PHASE_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_aux_oscillator_stopped,
    output logic [lcdbc_pkg::SEG_PINS-1:0] o_seg_on,
    output logic [lcdbc_pkg::COM_LINES-1:0] o_com_on,
    output logic o_drive_polarity,
    output lcdbc_pkg::lcdbc_supply_type o_supply_source,
    output logic o_pump_run,
    output logic o_pump_ext_ref,
    output logic [3:0] o_pump_target,
    output logic o_bias_gen_en,
    output logic o_bias_half,
    output logic o_rail_mid_ext,
    output logic o_rail_low_ext,
    output logic o_top_rail_pin_o,
    output logic o_top_rail_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic module_enable_bit;
        logic segments_visible;
        lcdbc_pkg::lcdbc_mux_type mux_rate_field;
        logic half_bias_select;
        logic [3:0] pump_voltage_setting;
        logic pump_enable;
        logic external_supply_select;
        logic [1:0] reference_select_field;
        logic external_bias_select;
        logic lowest_rail_external_select;
        logic [lcdbc_pkg::MEM_WORDS-1:0][31:0] mem;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [2:0] osc_sync;
        logic aux_oscillator_stopped;
        logic [31:0] div_cnt;
        logic [1:0] phase;
        logic polarity;
        lcdbc_pkg::lcdbc_supply_type supply;
        logic pump_run;
        logic pump_ext_ref;
        logic [3:0] pump_target;
        logic bias_gen_en;
        logic bias_half;
        logic rail_mid_ext;
        logic rail_low_ext;
        logic top_oe;
        logic top_out;
    } lcdbc_top_state_type;

    lcdbc_top_state_type r;
    lcdbc_top_state_type next_r;

    lcdbc_seg_if seg_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word-aligned offset in the decoded window, or out of range
    function automatic logic addr_in_map(input logic [31:0] a);
        addr_in_map = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00);
    endfunction

    // Memory word index for an offset in the memory window
    function automatic int mem_index(input logic [7:0] a);
        mem_index = int'((a - lcdbc_pkg::MEM_OFS) >> 2);
    endfunction

    function automatic logic is_mem(input logic [7:0] a);
        is_mem = (a >= lcdbc_pkg::MEM_OFS) && (mem_index(a) < lcdbc_pkg::MEM_WORDS);
    endfunction

    // Last phase of a frame for the given rate
    function automatic logic [1:0] last_phase(input lcdbc_pkg::lcdbc_mux_type m);
        case (m)
            lcdbc_pkg::MUX_STATIC: last_phase = 2'h0;
            lcdbc_pkg::MUX_2: last_phase = 2'h1;
            lcdbc_pkg::MUX_3: last_phase = 2'h2;
            lcdbc_pkg::MUX_4: last_phase = 2'h3;
            default: last_phase = 2'h0;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(input lcdbc_top_state_type s, input logic [7:0] a);
        logic [31:0] v;
        v = lcdbc_pkg::WORD_RESET;
        if (a == lcdbc_pkg::CTRL_OFS) begin
            v[lcdbc_pkg::CTRL_ENABLE_POS] = s.module_enable_bit;
            v[lcdbc_pkg::CTRL_VISIBLE_POS] = s.segments_visible;
            v[lcdbc_pkg::CTRL_MUX_POS +: 2] = s.mux_rate_field;
            v[lcdbc_pkg::CTRL_HALF_POS] = s.half_bias_select;
        end else if (a == lcdbc_pkg::VOLT_OFS) begin
            v[lcdbc_pkg::VOLT_LEVEL_POS +: 4] = s.pump_voltage_setting;
            v[lcdbc_pkg::VOLT_PUMP_EN_POS] = s.pump_enable;
            v[lcdbc_pkg::VOLT_EXT_SUP_POS] = s.external_supply_select;
            v[lcdbc_pkg::VOLT_REF_POS +: 2] = s.reference_select_field;
            v[lcdbc_pkg::VOLT_EXT_BIAS_POS] = s.external_bias_select;
            v[lcdbc_pkg::VOLT_LOW_EXT_POS] = s.lowest_rail_external_select;
        end else if (a == lcdbc_pkg::STAT_OFS) begin
            v[lcdbc_pkg::STAT_SUPPLY_POS +: 2] = s.supply;
            v[lcdbc_pkg::STAT_PUMP_RUN_POS] = s.pump_run;
            v[lcdbc_pkg::STAT_BIAS_EN_POS] = s.bias_gen_en;
            v[lcdbc_pkg::STAT_OSC_STOP_POS] = s.aux_oscillator_stopped;
            v[lcdbc_pkg::STAT_PHASE_POS +: 2] = s.phase;
            v[lcdbc_pkg::STAT_POL_POS] = s.polarity;
        end else if (is_mem(a)) begin
            v = s.mem[mem_index(a)];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic addr_phase;
    logic gen_ok;
    logic pump_wanted;
    logic multiplexed;

    always_comb begin
        next_r = r;
        addr_phase = i_hsel && i_htrans[1] && i_hready;

        // Bus write data phase; applied before any read so a back-to-back
        // read of the same word sees the new value
        next_r.wr_pend = 1'b0;
        if (r.wr_pend) begin
            if (r.wr_addr == lcdbc_pkg::CTRL_OFS) begin
                next_r.module_enable_bit = i_hwdata[lcdbc_pkg::CTRL_ENABLE_POS];
                next_r.segments_visible = i_hwdata[lcdbc_pkg::CTRL_VISIBLE_POS];
                next_r.mux_rate_field =
                    lcdbc_pkg::lcdbc_mux_type'(i_hwdata[lcdbc_pkg::CTRL_MUX_POS +: 2]);
                next_r.half_bias_select = i_hwdata[lcdbc_pkg::CTRL_HALF_POS];
            end else if (r.wr_addr == lcdbc_pkg::VOLT_OFS) begin
                next_r.pump_voltage_setting = i_hwdata[lcdbc_pkg::VOLT_LEVEL_POS +: 4];
                next_r.pump_enable = i_hwdata[lcdbc_pkg::VOLT_PUMP_EN_POS];
                next_r.external_supply_select = i_hwdata[lcdbc_pkg::VOLT_EXT_SUP_POS];
                next_r.reference_select_field = i_hwdata[lcdbc_pkg::VOLT_REF_POS +: 2];
                next_r.external_bias_select = i_hwdata[lcdbc_pkg::VOLT_EXT_BIAS_POS];
                next_r.lowest_rail_external_select = i_hwdata[lcdbc_pkg::VOLT_LOW_EXT_POS];
            end else if (is_mem(r.wr_addr)) begin
                next_r.mem[mem_index(r.wr_addr)] = i_hwdata;
            end
        end

        // Address phase; unmapped accesses read zero and write nothing; non-word writes are dropped, non-word reads return the word
        if (addr_phase) begin
            if (i_hwrite) begin
                next_r.wr_pend = addr_in_map(i_haddr) && (i_hsize == lcdbc_pkg::HSIZE_WORD);
                next_r.wr_addr = i_haddr[7:0];
            end else if (addr_in_map(i_haddr)) begin
                next_r.rdata = reg_read(next_r, i_haddr[7:0]);
            end else begin
                next_r.rdata = lcdbc_pkg::WORD_RESET;
            end
        end

        // Pin input: counted only once the second and third stages agree
        next_r.osc_sync = {r.osc_sync[1:0], i_aux_oscillator_stopped};
        if (r.osc_sync[1] == r.osc_sync[2]) begin
            next_r.aux_oscillator_stopped = r.osc_sync[2];
        end

        // Common-line sequencing; one polarity flip per frame keeps drive ac
        if (!r.module_enable_bit) begin
            next_r.div_cnt = 32'h0000_0000;
            next_r.phase = 2'h0;
            next_r.polarity = 1'b0;
        end else if (r.phase > last_phase(next_r.mux_rate_field)) begin
            // Shrinking the rate wraps in the write's own cycle, never overruns
            next_r.div_cnt = 32'h0000_0000;
            next_r.phase = 2'h0;
        end else if (r.div_cnt >= 32'(PHASE_CYCLES - 1)) begin
            next_r.div_cnt = 32'h0000_0000;
            if (r.phase >= last_phase(next_r.mux_rate_field)) begin
                next_r.phase = 2'h0;
                next_r.polarity = !r.polarity;
            end else begin
                next_r.phase = r.phase + 2'h1;
            end
        end else begin
            next_r.div_cnt = r.div_cnt + 32'h0000_0001;
        end

        // Supply and bias steering
        gen_ok = r.module_enable_bit && !r.aux_oscillator_stopped;
        multiplexed = r.mux_rate_field != lcdbc_pkg::MUX_STATIC;
        pump_wanted = (r.pump_voltage_setting != lcdbc_pkg::LEVEL_OFF)
            || (r.reference_select_field == lcdbc_pkg::REF_EXT_PIN);
        next_r.pump_run = !r.external_supply_select && r.pump_enable
            && pump_wanted && gen_ok;
        if (r.external_supply_select) begin
            next_r.supply = lcdbc_pkg::SUP_EXT_PIN;
        end else if (r.pump_voltage_setting == lcdbc_pkg::LEVEL_OFF
                     && r.reference_select_field == lcdbc_pkg::REF_NONE) begin
            next_r.supply = lcdbc_pkg::SUP_AVCC;
        end else if (next_r.pump_run) begin
            next_r.supply = lcdbc_pkg::SUP_PUMP;
        end else begin
            // Pump paused: the capacitor charge carries the glass
            next_r.supply = lcdbc_pkg::SUP_HELD;
        end
        next_r.pump_ext_ref = r.reference_select_field == lcdbc_pkg::REF_EXT_PIN;
        next_r.pump_target = next_r.pump_ext_ref ? lcdbc_pkg::LEVEL_OFF
                                                 : r.pump_voltage_setting;
        next_r.bias_gen_en = gen_ok && !r.external_bias_select
            && multiplexed;
        next_r.bias_half = multiplexed && r.half_bias_select;
        next_r.rail_mid_ext = r.external_bias_select;
        next_r.rail_low_ext = r.lowest_rail_external_select;
        // Switched top rail lets the ladder be powered down with the module
        next_r.top_oe = r.external_bias_select && !r.external_supply_select;
        next_r.top_out = next_r.top_oe && gen_ok;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment gating

    assign seg_bus.mem = r.mem;
    assign seg_bus.phase = r.phase;
    assign seg_bus.enable = r.module_enable_bit;
    assign seg_bus.visible = r.segments_visible;
    assign seg_bus.polarity = r.polarity;

    lcdbc_segmux u_segmux (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .seg(seg_bus.mux)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait states: every access completes in its first data cycle
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = r.rdata;
    assign o_seg_on = seg_bus.seg_on;
    assign o_com_on = seg_bus.com_on;
    assign o_drive_polarity = seg_bus.drive_pol;
    assign o_supply_source = r.supply;
    assign o_pump_run = r.pump_run;
    assign o_pump_ext_ref = r.pump_ext_ref;
    assign o_pump_target = r.pump_target;
    assign o_bias_gen_en = r.bias_gen_en;
    assign o_bias_half = r.bias_half;
    assign o_rail_mid_ext = r.rail_mid_ext;
    assign o_rail_low_ext = r.rail_low_ext;
    assign o_top_rail_pin_o = r.top_out;
    assign o_top_rail_pin_oe = r.top_oe;

endmodule

// ===== bench/lcdbc_glass.sv
/*
 * Behavioural glass: keeps the last segment state seen on each common line.
 * Assumes one-hot commons and the segment pins of the drive block.
 */
`timescale 1ns/100ps
module lcdbc_glass (
    input wire logic i_ref_clk,
    input wire logic i_clear,
    input wire logic [lcdbc_pkg::SEG_PINS-1:0] i_seg_on,
    input wire logic [lcdbc_pkg::COM_LINES-1:0] i_com_on,
    output logic [lcdbc_pkg::MEM_BITS-1:0] o_image
);
    ////////////////////////////////////////////////////////////////////////////
    // A segment is only seen while its common line is active
    always_ff @(posedge i_ref_clk) begin
        if (i_clear) begin
            o_image <= '0;
        end else begin
            for (int s = 0; s < lcdbc_pkg::SEG_PINS; s++) begin
                for (int k = 0; k < lcdbc_pkg::COM_LINES; k++) begin
                    if (i_com_on[k]) begin
                        o_image[s*4+k] <= i_seg_on[s];
                    end
                end
            end
        end
    end
endmodule

// ===== bench/lcdbc_top_asserts.sv
/*
 * Output relations of the LCD drive block.
 * Assumes it is bound to lcdbc_top and sees only its ports.
 */
`timescale 1ns/100ps
module lcdbc_top_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_aux_oscillator_stopped,
    input wire logic [lcdbc_pkg::SEG_PINS-1:0] o_seg_on,
    input wire logic [lcdbc_pkg::COM_LINES-1:0] o_com_on,
    input wire logic o_drive_polarity,
    input wire lcdbc_pkg::lcdbc_supply_type o_supply_source,
    input wire logic o_pump_run,
    input wire logic o_pump_ext_ref,
    input wire logic [3:0] o_pump_target,
    input wire logic o_bias_gen_en,
    input wire logic o_rail_mid_ext,
    input wire logic o_top_rail_pin_o,
    input wire logic o_top_rail_pin_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Six samples cover the three-flop synchroniser, the agreement flop and the output flop
    sequence osc_held;
        i_aux_oscillator_stopped [*6];
    endsequence
    sequence gen_off;
        !o_pump_run && !o_bias_gen_en && !o_top_rail_pin_o;
    endsequence

    AST_OSC_STOP_GATES: assert property (osc_held |=> gen_off)
        else $error("generation active with oscillator stopped");
    AST_PUMP_IS_SOURCE: assert property (
        o_pump_run |-> o_supply_source == lcdbc_pkg::SUP_PUMP)
        else $error("pump runs but is not the supply");
    AST_EXT_SUPPLY: assert property (
        o_supply_source == lcdbc_pkg::SUP_EXT_PIN |-> !o_pump_run && !o_top_rail_pin_oe)
        else $error("pump or rail drive active with external supply");
    AST_EXT_REF_LEVEL: assert property (o_pump_ext_ref |-> o_pump_target == 4'h0)
        else $error("pump level used with external reference");
    AST_EXT_BIAS_GEN: assert property (o_rail_mid_ext |-> !o_bias_gen_en)
        else $error("bias generator on with external rails");
    AST_TOP_RAIL: assert property (
        o_top_rail_pin_o |-> o_top_rail_pin_oe && o_rail_mid_ext)
        else $error("top rail driven without external divider");
    AST_COM_ONE_HOT: assert property ($onehot0(o_com_on))
        else $error("more than one common active");
    AST_DISABLED_QUIET: assert property (
        o_com_on == 4'h0 |-> o_seg_on == '0 && !o_drive_polarity)
        else $error("segments driven with no common active");
endmodule

bind lcdbc_top lcdbc_top_asserts u_asserts (.i_ref_clk, .i_rst_n, .i_aux_oscillator_stopped,
    .o_seg_on, .o_com_on, .o_drive_polarity, .o_supply_source, .o_pump_run, .o_pump_ext_ref,
    .o_pump_target, .o_bias_gen_en, .o_rail_mid_ext, .o_top_rail_pin_o, .o_top_rail_pin_oe);

// ===== bench/testbench.sv
/*
 * Self-checking bench: AHB-Lite register calls with expected outputs.
 * Assumes the short phase parameter of 4 cycles.
 */
`timescale 1ns/100ps
module testbench;
    logic i_ref_clk, i_rst_n, i_hsel, i_hwrite, i_aux_oscillator_stopped, clr;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, q;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    wire logic i_hready;
    logic o_hreadyout, o_hresp, o_drive_polarity, o_pump_run, o_pump_ext_ref, o_bias_gen_en;
    logic o_bias_half, o_rail_mid_ext, o_rail_low_ext, o_top_rail_pin_o, o_top_rail_pin_oe;
    logic [39:0] o_seg_on;
    logic [3:0] o_com_on, o_pump_target, nib;
    logic [159:0] image;
    lcdbc_pkg::lcdbc_supply_type o_supply_source;
    int failures = 0;
    int n_checks = 0;
    assign i_hready = o_hreadyout;

    lcdbc_top #(.PHASE_CYCLES(4)) DUT (.i_ref_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
        .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata,
        .i_aux_oscillator_stopped, .o_seg_on, .o_com_on, .o_drive_polarity, .o_supply_source,
        .o_pump_run, .o_pump_ext_ref, .o_pump_target, .o_bias_gen_en, .o_bias_half,
        .o_rail_mid_ext, .o_rail_low_ext, .o_top_rail_pin_o, .o_top_rail_pin_oe);
    lcdbc_glass u_glass (.i_ref_clk, .i_clear(clr), .i_seg_on(o_seg_on), .i_com_on(o_com_on),
        .o_image(image));

    ////////////////////////////////////////////////////////////////////////////
    // Fixed 10 ns clock stands in for the reference clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic tally_and_finish;
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_hsel <= 1'b1;
        i_haddr <= {24'h000000, a};
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_hsize <= lcdbc_pkg::HSIZE_WORD;
        do @(posedge i_ref_clk); while (i_hready !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_ref_clk); while (i_hready !== 1'b1);
        q = o_hrdata;
        chk("hresp", {31'h0, o_hresp}, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic sup(input logic [31:0] c, v, input logic osc, input logic [2:0] e);
        i_aux_oscillator_stopped <= osc;
        xfer(1'b1, lcdbc_pkg::CTRL_OFS, c);
        xfer(1'b1, lcdbc_pkg::VOLT_OFS, v);
        idle(8);
        xfer(1'b0, lcdbc_pkg::STAT_OFS, 32'h0);
        chk("supply", {29'h0, o_pump_run, o_supply_source}, {29'h0, e});
        chk("status", q & 32'h17, {27'h0, osc, 1'b0, e});
    endtask

    task automatic glass(input logic [31:0] c, input logic [31:0] exp);
        xfer(1'b1, lcdbc_pkg::CTRL_OFS, c);
        clr <= 1'b1;
        idle(1);
        clr <= 1'b0;
        idle(40);
        chk("glass", image[31:0], exp);
    endtask

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        {i_rst_n, i_hsel, i_hwrite, i_aux_oscillator_stopped, clr} = 5'h00;
        {i_haddr, i_hwdata, i_htrans, i_hsize} = 69'h0;
        idle(4);
        i_rst_n <= 1'b1;
        idle(1);
        xfer(1'b0, lcdbc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl reset", q, lcdbc_pkg::WORD_RESET);
        xfer(1'b1, 8'h24, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h24, 32'h0);
        chk("unmapped", q, 32'h0);
        sup(32'h01, 32'h000, 1'b0, 3'h0);
        sup(32'h01, 32'h015, 1'b0, 3'h5);
        sup(32'h01, 32'h005, 1'b0, 3'h2);
        sup(32'h01, 32'h057, 1'b0, 3'h5);
        chk("ext ref", {27'h0, o_pump_ext_ref, o_pump_target}, 32'h10);
        sup(32'h01, 32'h035, 1'b0, 3'h3);
        sup(32'h00, 32'h015, 1'b0, 3'h2);
        sup(32'h19, 32'h015, 1'b1, 3'h2);
        chk("osc bias", {31'h0, o_bias_gen_en}, 32'h0);
        i_aux_oscillator_stopped <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            for (int h = 0; h < 2; h++) begin
                xfer(1'b1, lcdbc_pkg::CTRL_OFS, 32'h01 | (m << 3) | (h << 5));
                xfer(1'b1, lcdbc_pkg::VOLT_OFS, 32'h0);
                idle(3);
                chk("bias", {o_bias_gen_en, o_bias_half},
                    {m != 0, h == 1 && m != 0});
            end
        end
        xfer(1'b1, lcdbc_pkg::VOLT_OFS, 32'h300);
        idle(3);
        chk("rails",
            {o_bias_gen_en, o_rail_mid_ext, o_rail_low_ext, o_top_rail_pin_oe, o_top_rail_pin_o},
            32'h0F);
        xfer(1'b1, lcdbc_pkg::VOLT_OFS, 32'h320);
        idle(3);
        chk("rail in", {o_rail_mid_ext, o_top_rail_pin_oe, o_top_rail_pin_o}, 32'h4);
        xfer(1'b1, lcdbc_pkg::VOLT_OFS, 32'h200);
        idle(3);
        chk("low rail", {o_bias_gen_en, o_rail_mid_ext, o_rail_low_ext}, 32'h5);
        xfer(1'b1, lcdbc_pkg::MEM_OFS, 32'hA5C3_1E69);
        xfer(1'b0, lcdbc_pkg::MEM_OFS, 32'h0);
        chk("mem word", q, 32'hA5C3_1E69);
        // Unused commons must leave their segments dark on the glass
        for (int m = 0; m < 4; m++) begin
            nib = 4'((1 << (m + 1)) - 1);
            glass(32'h05 | (m << 3), 32'hA5C3_1E69 & {8{nib}});
        end
        glass(32'h19, 32'h0);
        chk("blank", o_seg_on[31:0], 32'h0);
        xfer(1'b1, lcdbc_pkg::CTRL_OFS, 32'h0);
        idle(4);
        chk("off", {o_com_on, o_seg_on[27:0]}, 32'h0);
        chk("off pol", {31'h0, o_drive_polarity}, 32'h0);
        tally_and_finish();
    end
endmodule
